// ### rtl/cfgp_pin_ctrl.sv
// Configuration port pin controller: mode straps, handshake lines, clock and data pins
// How it works
// - Mode straps are sampled at power-on or program request and pick active pins.
// - A falling program request puts the device back into configuration.
// - Program request is ignored while the boundary-scan port owns the device.
// - Init is pulled low, memory cleared and PROM reset while program is low.
// - Configuration does not start while the init line is held low outside.
// - During configuration init is pulled low on any configuration error unless a parallel mode has a select high.
// - Done is low while unprogrammed, released when init, program high and done set.
// - An open-drain done held low outside may delay wake-up until released.
// - Master modes drive the config clock from the internal oscillator; else input.
// - Master clock runs a number of extra clocks after wake-up, then tristates.
// - Configuration pins except SPI flash select, serial out and busy in bypass are tristated after configuration, with weak pull-ups unless the port is kept.
// - Serial modes take data on the serial input pin, which has a pull-up.
// - SPI modes drive flash select, high whenever SPI configuration is not running.
// - Byte pins are inputs on write with selects low, outputs on read.
// - Byte pins stay watched for read-back after configuration only if kept.
// - SPI data pins carry one flash each and are interleaved into bytes.
// - Extended SPI samples byte-pin straps to pick the flash read opcode.
// - With bypass, configured device passes incoming data through to serial out.
// - Parallel bypass sends each byte out bit zero first, ascending.
// - Serial out drives high until the bypass or flow-through step executes.
// - In parallel modes either select high tristates byte, busy and error init; both high clear bypass.
// - Strap codes map to the six documented modes.
// - Busy is driven low only when a byte can be taken or is ready to read.
`timescale 1ns/1ps
module cfgp_pin_ctrl
  import cfgp_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              nrst,
  // Straps and program request pins
  input  wire logic [2:0]        modeStrap,
  input  wire logic              programRequestLow,
  input  wire logic              jtagActive,
  // Init/error open-drain line
  input  wire logic              initErrorLineIn,
  output logic                   initErrorLineOut,
  output logic                   initErrorLineOe,
  // Done line
  input  wire logic              doneLineIn,
  output logic                   doneLineOut,
  output logic                   doneLineOe,
  // Configuration clock
  input  wire logic              configClockIn,
  output logic                   configClockOut,
  output logic                   configClockOe,
  // Serial input or flash select
  input  wire logic              serialInOrFlashSelectIn,
  output logic                   serialInOrFlashSelectOut,
  output logic                   serialInOrFlashSelectOe,
  // Byte port
  input  wire logic [DATA_W-1:0] dataPinIn,
  output logic      [DATA_W-1:0] dataPinOut,
  output logic                   dataPinOe,
  input  wire logic              chipSelectALow,
  input  wire logic              chipSelectBLow,
  input  wire logic              writeDirectionLow,
  output logic                   busyOut,
  output logic                   busyOe,
  // Chain output
  output logic                   serialOutOrChainSelect,
  // Option bits
  input  wire logic              doneOpenDrain,
  input  wire logic              wakeWaitsDone,
  input  wire logic              keepPortAfterConfig,
  input  wire logic              bypassEnable,
  input  wire logic              flowThroughEnable,
  input  wire logic              spiWide,
  // Configuration engine side
  input  wire logic              doneBitProgrammed,
  input  wire logic              configError,
  input  wire logic              wakeupComplete,
  output logic      [DATA_W-1:0] cfgData,
  output logic                   cfgValid,
  input  wire logic              cfgReady,
  input  wire logic [DATA_W-1:0] readbackData,
  input  wire logic              readbackValid,
  output logic                   readbackTake,
  // Status
  output logic      [2:0]        configMode,
  output logic      [7:0]        readOpcodeStrap,
  output logic                   clearMemory,
  output logic                   weakPullUpEnable,
  output logic                   userMode
);
  localparam int SW = 3 + 1 + 1 + 1 + 1 + 1 + 1 + 1 + 1 + DATA_W;

  // Pin synchronisers: the first stage feeds only the second
  logic [SW-1:0] meta_q, sync_q;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      meta_q <= '1;
      sync_q <= '1;
    end else begin
      meta_q <= {modeStrap, programRequestLow, initErrorLineIn, doneLineIn, configClockIn,
                 serialInOrFlashSelectIn, chipSelectALow, chipSelectBLow, writeDirectionLow, dataPinIn};
      sync_q <= meta_q;
    end
  end

  logic [2:0]        strapS;
  logic              progS, initS, doneS, cclkS, diS, csAS, csBS, wrS;
  logic [DATA_W-1:0] dataS;
  assign {strapS, progS, initS, doneS, cclkS, diS, csAS, csBS, wrS, dataS} = sync_q;

  // Edge history of synchronised pins
  logic progPrev_q, cclkPrev_q;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      progPrev_q <= 1'b1;
      cclkPrev_q <= 1'b1;
    end else begin
      progPrev_q <= progS;
      cclkPrev_q <= cclkS;
    end
  end

  logic progFall;
  assign progFall = progPrev_q && !progS && !jtagActive;

  // Sequence state
  cfgp_state_t state_q, state_d;
  logic [2:0]  mode_q, mode_d;
  logic [7:0]  opcode_q, opcode_d;
  logic [4:0]  clrCnt_q, clrCnt_d;
  logic [8:0]  tail_q, tail_d;
  logic        err_q, err_d;
  logic        overrun;
  logic        ownRise;
  logic        master, spi, par;

  assign master = isMaster(mode_q);
  assign spi    = isSpi(mode_q);
  assign par    = isParallel(mode_q);

  // Next state of the configuration sequence
  always_comb begin
    state_d  = state_q;
    mode_d   = mode_q;
    opcode_d = opcode_q;
    clrCnt_d = clrCnt_q;
    tail_d   = tail_q;
    err_d    = err_q;
    case (state_q)
      ST_POR: begin
        state_d  = ST_CLEAR;
        clrCnt_d = '0;
      end
      ST_CLEAR: begin
        if (clrCnt_q != 5'(CLEAR_CYC)) begin
          clrCnt_d = 5'(clrCnt_q + 1'b1);
        end else if (progS || jtagActive) begin
          state_d  = ST_WAIT;
          mode_d   = strapS;
          opcode_d = (strapS == MODE_EXTENDED_FLASH_MODE) ? dataS : OPCODE_RST;
        end
      end
      ST_WAIT: begin
        if (initS) begin
          state_d = ST_CFG;
          err_d   = 1'b0;
        end
      end
      ST_CFG: begin
        if (configError || overrun) begin
          err_d = 1'b1;
        end
        if (doneBitProgrammed && !err_q) begin
          state_d = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (wakeupComplete && (doneS || !wakeWaitsDone)) begin
          state_d = master ? ST_TAIL : ST_USER;
          tail_d  = '0;
        end
      end
      ST_TAIL: begin
        if (tail_q == TAIL_CLOCKS) begin
          state_d = ST_USER;
        end else if (ownRise) begin
          tail_d = 9'(tail_q + 1'b1);
        end
      end
      ST_USER: begin
        state_d = ST_USER;
      end
      default: begin
        state_d = ST_POR;
      end
    endcase
    // Program request restarts from any state unless scan owns the device
    if (progFall) begin
      state_d  = ST_CLEAR;
      clrCnt_d = '0;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_q  <= ST_POR;
      mode_q   <= MODE_SSER;
      opcode_q <= OPCODE_RST;
      clrCnt_q <= '0;
      tail_q   <= '0;
      err_q    <= 1'b0;
    end else begin
      state_q  <= state_d;
      mode_q   <= mode_d;
      opcode_q <= opcode_d;
      clrCnt_q <= clrCnt_d;
      tail_q   <= tail_d;
      err_q    <= err_d;
    end
  end

  logic configuring, configured;
  assign configuring = (state_q == ST_CFG);
  assign configured  = doneBitProgrammed && (state_q >= ST_WAKE);

  // Master clock divider; stalls while the FIFO is full so no byte is lost
  logic [3:0] div_q, div_d;
  logic       config_clock_q, config_clock_d;
  logic       clkRun, fifoInReady;
  assign clkRun = master && (configuring || state_q == ST_WAKE || state_q == ST_TAIL)
                  && (fifoInReady || configured);
  always_comb begin
    div_d  = div_q;
    config_clock_d = config_clock_q;
    if (!clkRun) begin
      div_d  = '0;
      config_clock_d = 1'b0;
    end else if (div_q == 4'(CONFIG_CLOCK_HALF - 1)) begin
      div_d  = '0;
      config_clock_d = !config_clock_q;
    end else begin
      div_d = 4'(div_q + 1'b1);
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      div_q  <= '0;
      config_clock_q <= 1'b0;
    end else begin
      div_q  <= div_d;
      config_clock_q <= config_clock_d;
    end
  end

  assign ownRise = clkRun && !config_clock_q && config_clock_d;

  logic edgeStb;
  assign edgeStb = master ? ownRise : (cclkS && !cclkPrev_q);

  // Byte assembly from serial, SPI or parallel pins
  logic [DATA_W-1:0] asm_q, asm_d, push_q, push_d;
  logic [2:0]        bitCnt_q, bitCnt_d;
  logic              pushV_q, pushV_d;
  logic              selLow, wrPort, rdPort, bothHigh;
  logic              bypassActive, bypByteReady, bypassOut;
  assign selLow   = !csAS && !csBS;
  assign bothHigh = csAS && csBS;
  assign wrPort   = par && selLow && !wrS;
  assign rdPort   = par && selLow && wrS && (configuring || keepPortAfterConfig);
  assign bypassActive = bypassEnable && configured;

  always_comb begin
    asm_d    = asm_q;
    bitCnt_d = bitCnt_q;
    push_d   = push_q;
    pushV_d  = 1'b0;
    if (edgeStb && configuring) begin
      if (par) begin
        if (wrPort) begin
          push_d  = dataS;
          pushV_d = 1'b1;
        end
      end else if (spi && spiWide) begin
        push_d  = dataS;
        pushV_d = 1'b1;
      end else begin
        asm_d    = {asm_q[DATA_W-2:0], spi ? dataS[0] : diS};
        bitCnt_d = 3'(bitCnt_q + 1'b1);
        if (bitCnt_q == 3'h7) begin
          push_d  = {asm_q[DATA_W-2:0], spi ? dataS[0] : diS};
          pushV_d = 1'b1;
        end
      end
    end
    if (state_q == ST_CLEAR) begin
      bitCnt_d = '0;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      asm_q    <= '0;
      bitCnt_q <= '0;
      push_q   <= '0;
      pushV_q  <= 1'b0;
    end else begin
      asm_q    <= asm_d;
      bitCnt_q <= bitCnt_d;
      push_q   <= push_d;
      pushV_q  <= pushV_d;
    end
  end

  // Slave data arriving with no room is a configuration error
  assign overrun = pushV_q && !fifoInReady;

  cfgp_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) uFifo (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .flush    (state_q == ST_CLEAR),
    .inData   (push_q),
    .inValid  (pushV_q),
    .inReady  (fifoInReady),
    .outData  (cfgData),
    .outValid (cfgValid),
    .outReady (cfgReady)
  );

  // Bypass path after configuration
  cfgp_bypass uBypass (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .clear     ((par && bothHigh) || state_q == ST_CLEAR),
    .byteMode  (par),
    .edgeStb   (edgeStb && bypassActive),
    .bitIn     (diS),
    .byteIn    (dataS),
    .byteValid (wrPort),
    .byteReady (bypByteReady),
    .serOut    (bypassOut)
  );

  // Read-back byte register
  logic [DATA_W-1:0] rdData_q, rdData_d;
  always_comb begin
    rdData_d     = rdData_q;
    readbackTake = 1'b0;
    if (rdPort && readbackValid && edgeStb) begin
      rdData_d     = readbackData;
      readbackTake = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdData_q <= '0;
    end else begin
      rdData_q <= rdData_d;
    end
  end

  // Init line: low while clearing, and on errors during configuration
  assign initErrorLineOut = 1'b0;
  assign initErrorLineOe  = (state_q == ST_CLEAR) || (state_q == ST_POR)
                            || (configuring && err_q && !(par && !selLow));
  assign clearMemory      = (state_q == ST_CLEAR);

  // Done line: low until programmed, then released or driven high
  logic doneRelease;
  assign doneRelease = configured && initS && progS;
  assign doneLineOut = doneRelease;
  assign doneLineOe  = !doneRelease || !doneOpenDrain;

  // Clock pin direction follows the sampled mode
  assign configClockOut = config_clock_q;
  assign configClockOe  = clkRun;

  // Flash select driven in SPI modes, low only while loading
  assign serialInOrFlashSelectOut = !(spi && configuring);
  assign serialInOrFlashSelectOe  = spi;

  // Byte port drive and busy handshake
  assign dataPinOut = rdData_q;
  assign dataPinOe  = rdPort;
  assign busyOut    = !((wrPort && (bypassActive ? bypByteReady : fifoInReady)) || (rdPort && readbackValid));
  assign busyOe     = par && selLow && (configuring || bypassActive || keepPortAfterConfig);

  // Chain output: high until bypass or flow-through takes over
  assign serialOutOrChainSelect = bypassActive ? bypassOut
                                  : !(flowThroughEnable && par && configured);

  // Status
  assign configMode       = mode_q;
  assign readOpcodeStrap  = opcode_q;
  assign userMode         = (state_q == ST_USER);
  assign weakPullUpEnable = (state_q == ST_USER) && !keepPortAfterConfig;

endmodule : cfgp_pin_ctrl

// ### rtl/cfgp_pkg.sv
// Shared constants, types and mode decoding for the configuration pin controller
package cfgp_pkg;

  // Strap codes of the configuration mode pins
  typedef enum logic [2:0] {
    MODE_THREE_WIRE_FLASH_MODE = 3'b000,
    MODE_EXTENDED_FLASH_MODE = 3'b001,
    MODE_MSER = 3'b100,
    MODE_SSER = 3'b101,
    MODE_MPAR = 3'b110,
    MODE_SPAR = 3'b111
  } cfgp_mode_t;

  // Controller sequence
  typedef enum logic [2:0] {
    ST_POR   = 3'b000,
    ST_CLEAR = 3'b001,
    ST_WAIT  = 3'b010,
    ST_CFG   = 3'b011,
    ST_WAKE  = 3'b100,
    ST_TAIL  = 3'b101,
    ST_USER  = 3'b110
  } cfgp_state_t;

  localparam int          DATA_W       = 8;
  localparam int          FIFO_DEPTH   = 8;
  localparam int          SYS_CLK_MHZ  = 100;
  // Least time the init line is pulled low for memory clearing
  localparam int          CLEAR_NS     = 160;
  localparam int          CLEAR_CYC    = (CLEAR_NS * SYS_CLK_MHZ + 999) / 1000;
  // Half period of the master configuration clock
  localparam int          CONFIG_CLOCK_HALF_NS = 40;
  localparam int          CONFIG_CLOCK_HALF    = (CONFIG_CLOCK_HALF_NS * SYS_CLK_MHZ) / 1000;
  // Extra master clocks after wake-up, inside the 100 to 500 window
  localparam int          TAIL_MIN     = 100;
  localparam int          TAIL_MAX     = 500;
  localparam logic [8:0]  TAIL_CLOCKS  = 9'h100;
  localparam logic [7:0]  OPCODE_RST   = 8'h00;
  localparam logic        BYPASS_RST   = 1'b1;

  function automatic logic isMaster(input logic [2:0] m);
    return (m == MODE_MSER) || (m == MODE_MPAR) || (m == MODE_THREE_WIRE_FLASH_MODE) || (m == MODE_EXTENDED_FLASH_MODE);
  endfunction : isMaster

  function automatic logic isSpi(input logic [2:0] m);
    return (m == MODE_THREE_WIRE_FLASH_MODE) || (m == MODE_EXTENDED_FLASH_MODE);
  endfunction : isSpi

  function automatic logic isParallel(input logic [2:0] m);
    return (m == MODE_MPAR) || (m == MODE_SPAR);
  endfunction : isParallel

endpackage : cfgp_pkg

// ### rtl/cfgp_fifo.sv
// Small synchronous FIFO between the pin sampler and the configuration engine
`timescale 1ns/1ps
module cfgp_fifo
  import cfgp_pkg::*;
#(
  parameter int WIDTH = DATA_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             nrst,
  input  wire logic             flush,
  // Fill side
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  // Drain side
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [AW:0]      count_q, count_d;
  logic             push, pop;

  // Honest flags from the fill count
  assign inReady  = (count_q < (AW + 1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign outData  = mem[rdPtr_q];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  // Pointer and count update
  always_comb begin
    wrPtr_d = push ? AW'(wrPtr_q + 1'b1) : wrPtr_q;
    rdPtr_d = pop ? AW'(rdPtr_q + 1'b1) : rdPtr_q;
    count_d = (AW + 1)'(count_q + push - pop);
    if (flush) begin
      wrPtr_d = '0;
      rdPtr_d = '0;
      count_d = '0;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      count_q <= count_d;
    end
  end

  // Storage has no reset; only written words are ever read
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

endmodule : cfgp_fifo

// ### rtl/cfgp_bypass.sv
// Bypass register that passes chain data to the next device, LSB first for bytes
`timescale 1ns/1ps
module cfgp_bypass
  import cfgp_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              nrst,
  input  wire logic              clear,
  // Control
  input  wire logic              byteMode,
  input  wire logic              edgeStb,
  // Data in
  input  wire logic              bitIn,
  input  wire logic [DATA_W-1:0] byteIn,
  input  wire logic              byteValid,
  output logic                   byteReady,
  // Serial out
  output logic                   serOut
);
  logic [DATA_W-1:0] shift_q, shift_d;
  logic [2:0]        left_q, left_d;
  logic              out_q, out_d;

  assign byteReady = byteMode && (left_q == 3'h0);
  assign serOut    = out_q;

  // One bit per configuration clock edge
  always_comb begin
    shift_d = shift_q;
    left_d  = left_q;
    out_d   = out_q;
    if (clear) begin
      shift_d = '0;
      left_d  = 3'h0;
      out_d   = BYPASS_RST;
    end else if (edgeStb && !byteMode) begin
      out_d = bitIn;
    end else if (edgeStb && left_q != 3'h0) begin
      out_d   = shift_q[0];
      shift_d = {1'b0, shift_q[DATA_W-1:1]};
      left_d  = 3'(left_q - 1'b1);
    end else if (edgeStb && byteValid) begin
      out_d   = byteIn[0];
      shift_d = {1'b0, byteIn[DATA_W-1:1]};
      left_d  = 3'h7;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      shift_q <= '0;
      left_q  <= 3'h0;
      out_q   <= BYPASS_RST;
    end else begin
      shift_q <= shift_d;
      left_q  <= left_d;
      out_q   <= out_d;
    end
  end

endmodule : cfgp_bypass

// ### bench/cfgp_host_model.sv
// Slave serial host that feeds bytes on its own link clock
`timescale 1ns/1ps
module cfgp_host_model (
  // Link pins
  output logic linkClk,
  output logic linkData
);
  // Clock rests low and data floats to the pull-up outside frames
  initial begin
    linkClk  = 1'b0;
    linkData = 1'b1;
  end

  // Data moves while the clock is low, bit 7 goes first
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      linkData = b[i];
      #62.5 linkClk = 1'b1;
      #62.5 linkClk = 1'b0;
    end
    #62.5 linkData = 1'b1;
    #62.5;
  endtask : send_byte
endmodule : cfgp_host_model

// ### bench/cfgp_pin_ctrl_chk.sv
// Port checker for the configuration pin controller
`timescale 1ns/1ps
module cfgp_pin_ctrl_chk
  import cfgp_pkg::*;
(
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       nrst,
  // Control pins
  input wire logic       programRequestLow,
  input wire logic       jtagActive,
  input wire logic       chipSelectALow,
  input wire logic       chipSelectBLow,
  input wire logic       doneBitProgrammed,
  // Driven pins
  input wire logic       initErrorLineOut,
  input wire logic       initErrorLineOe,
  input wire logic       doneLineOut,
  input wire logic       doneLineOe,
  input wire logic       configClockOe,
  input wire logic       serialInOrFlashSelectOut,
  input wire logic       serialInOrFlashSelectOe,
  input wire logic       dataPinOe,
  input wire logic       busyOe,
  input wire logic       serialOutOrChainSelect,
  // Status
  input wire logic [2:0] configMode,
  input wire logic       clearMemory,
  input wire logic       userMode
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  // Program request falls with the scan port idle or busy
  sequence progFall;
    $fell(programRequestLow) && !jtagActive ##1 !jtagActive [*5];
  endsequence
  sequence scanFall;
    $fell(programRequestLow) && jtagActive ##1 jtagActive [*5];
  endsequence
  sequence clearRun;
    clearMemory [*8];
  endsequence

  a_prog_restart: assert property (progFall |-> clearMemory) else $error("no clear after program");
  a_scan_ignore: assert property (scanFall |-> !clearMemory) else $error("program taken in scan");
  a_clear_hold: assert property ($rose(clearMemory) |-> clearRun) else $error("clear too short");
  a_clear_init: assert property (clearMemory |-> initErrorLineOe && !initErrorLineOut)
    else $error("init not low in clear");
  a_done_low: assert property (!doneBitProgrammed [*2] |-> doneLineOe && !doneLineOut)
    else $error("done not low");
  a_slave_clk_in: assert property (configMode == MODE_SSER || configMode == MODE_SPAR |-> !configClockOe)
    else $error("slave drives clock");
  a_user_clk_off: assert property (userMode [*2] |-> !configClockOe) else $error("clock runs in user");
  a_flash_idle: assert property (userMode && serialInOrFlashSelectOe |-> serialInOrFlashSelectOut)
    else $error("flash select low idle");
  a_chain_high: assert property (clearMemory [*2] |-> serialOutOrChainSelect) else $error("chain out low");
  a_select_tri: assert property ((chipSelectALow || chipSelectBLow) [*4] |-> !busyOe && !dataPinOe)
    else $error("byte port driven");
endmodule : cfgp_pin_ctrl_chk

bind cfgp_pin_ctrl cfgp_pin_ctrl_chk chk (
  .clk_sys, .nrst, .programRequestLow, .jtagActive, .chipSelectALow, .chipSelectBLow,
  .doneBitProgrammed, .initErrorLineOut, .initErrorLineOe, .doneLineOut, .doneLineOe,
  .configClockOe, .serialInOrFlashSelectOut, .serialInOrFlashSelectOe, .dataPinOe, .busyOe,
  .serialOutOrChainSelect, .configMode, .clearMemory, .userMode
);

// ### bench/cfgp_pin_ctrl_test.sv
// Self-checking bench for the configuration pin controller
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_count++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, (a), (e)); end end
module cfgp_pin_ctrl_test
  import cfgp_pkg::*;
;
  logic clk_sys = 1'b0, nrst = 1'b0, programRequestLow = 1'b1, jtagActive = 1'b0, initHold = 1'b1;
  logic doneHold = 1'b0, chipSelectALow = 1'b1, chipSelectBLow = 1'b1, writeDirectionLow = 1'b1;
  logic doneOpenDrain = 1'b1, wakeWaitsDone = 1'b1, keepPortAfterConfig = 1'b0, bypassEnable = 1'b0;
  logic flowThroughEnable = 1'b0, spiWide = 1'b0, doneBitProgrammed = 1'b0, configError = 1'b0;
  logic wakeupComplete = 1'b0, cfgReady = 1'b0, readbackValid = 1'b0, track = 1'b0, seen, last;
  logic [2:0] modeStrap = 3'b101, m;
  logic [7:0] dataPinIn = 8'h00, readbackData = 8'h00, b, expByte;
  logic initErrorLineOut, initErrorLineOe, doneLineOut, doneLineOe, configClockOut, configClockOe;
  logic serialInOrFlashSelectOut, serialInOrFlashSelectOe, dataPinOe, busyOut, busyOe, cfgValid;
  logic serialOutOrChainSelect, readbackTake, clearMemory, weakPullUpEnable, userMode;
  logic [7:0] dataPinOut, cfgData, readOpcodeStrap;
  logic [2:0] configMode;
  logic [2:0] modes [6] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6, 3'h7};
  logic [7:0] expQ [$];
  int err_count = 0, tests_run = 0, seed = 88786, n;
  wire logic linkClk, linkData;

  // Open-drain and shared pin levels from every driver
  wire logic initWire = ~(initErrorLineOe & ~initErrorLineOut) & ~initHold;
  wire logic doneWire = doneLineOe ? doneLineOut : ~doneHold;
  wire logic cclkWire = configClockOe ? configClockOut : linkClk;
  wire logic diWire   = serialInOrFlashSelectOe ? serialInOrFlashSelectOut : linkData;

  cfgp_pin_ctrl DUT (
    .clk_sys, .nrst, .modeStrap, .programRequestLow, .jtagActive, .initErrorLineIn(initWire),
    .initErrorLineOut, .initErrorLineOe, .doneLineIn(doneWire), .doneLineOut, .doneLineOe,
    .configClockIn(cclkWire), .configClockOut, .configClockOe, .serialInOrFlashSelectIn(diWire),
    .serialInOrFlashSelectOut, .serialInOrFlashSelectOe, .dataPinIn, .dataPinOut, .dataPinOe,
    .chipSelectALow, .chipSelectBLow, .writeDirectionLow, .busyOut, .busyOe, .serialOutOrChainSelect,
    .doneOpenDrain, .wakeWaitsDone, .keepPortAfterConfig, .bypassEnable, .flowThroughEnable, .spiWide,
    .doneBitProgrammed, .configError, .wakeupComplete, .cfgData, .cfgValid, .cfgReady, .readbackData,
    .readbackValid, .readbackTake, .configMode, .readOpcodeStrap, .clearMemory, .weakPullUpEnable,
    .userMode
  );
  cfgp_host_model host (.linkClk, .linkData);

  // System clock
  initial forever #5 clk_sys = ~clk_sys;

  // Random drain stalls and idle byte traffic
  always @(posedge clk_sys) begin
    int r;
    r = $random(seed);
    {readbackValid, writeDirectionLow, cfgReady} <= r[2:0];
    dataPinIn <= r[15:8];
    readbackData <= r[23:16];
  end

  // Oldest note against each byte handed on
  always @(posedge clk_sys) begin
    if (track && cfgValid && cfgReady) begin
      expByte = (expQ.size() != 0) ? expQ.pop_front() : ~cfgData;
      `CHK(cfgData, expByte)
    end
  end

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
  endtask : cyc

  task automatic finish_test();
    $display("errors %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test

  // Hang guard, far beyond the expected run
  initial begin
    #400000;
    err_count++;
    finish_test();
  end

  // Main sequence
  initial begin
    cyc(8);
    nrst <= 1'b1;
    cyc(3);
    `CHK(clearMemory, 1'b1)
    `CHK(initErrorLineOe, 1'b1)
    `CHK(serialOutOrChainSelect, 1'b1)
    cyc(40);
    track <= 1'b1;
    host.send_byte(8'h5a);
    cyc(20);
    initHold <= 1'b0;
    cyc(10);
    for (int k = 0; k < 4; k++) begin
      b = 8'($random(seed));
      expQ.push_back(b);
      host.send_byte(b);
    end
    cyc(30);
    `CHK(expQ.size(), 0)
    `CHK(initErrorLineOe, 1'b0)
    configError <= 1'b1;
    cyc(3);
    `CHK(initErrorLineOe, 1'b1)
    configError <= 1'b0;
    jtagActive <= 1'b1;
    programRequestLow <= 1'b0;
    cyc(20);
    `CHK(clearMemory, 1'b0)
    programRequestLow <= 1'b1;
    cyc(5);
    jtagActive <= 1'b0;
    track <= 1'b0;
    // Every strap code through to user mode
    for (int i = 0; i < 6; i++) begin
      m = modes[i];
      modeStrap <= m;
      {keepPortAfterConfig, spiWide, bypassEnable} <= 3'(i);
      flowThroughEnable <= i[0];
      {chipSelectALow, chipSelectBLow} <= {2{~(m[2] & m[1])}};
      programRequestLow <= 1'b0;
      cyc(5);
      `CHK(clearMemory, 1'b1)
      programRequestLow <= 1'b1;
      cyc(40);
      `CHK(configMode, m)
      if (m != 3'h1) `CHK(readOpcodeStrap, OPCODE_RST)
      seen = 1'b0;
      repeat (20) begin
        @(posedge clk_sys);
        seen |= configClockOe;
      end
      `CHK(seen, ~m[2] | ~m[0])
      if (!m[2]) `CHK(serialInOrFlashSelectOe, 1'b1)
      if (m[2] & m[1]) `CHK(busyOe, 1'b1)
      doneHold <= (i == 0);
      doneBitProgrammed <= 1'b1;
      wakeupComplete <= 1'b1;
      if (i == 0) begin
        cyc(200);
        `CHK(userMode, 1'b0)
        doneHold <= 1'b0;
      end
      n = 0;
      last = 1'b1;
      for (int t = 0; t < 4000 && userMode !== 1'b1; t++) begin
        @(posedge clk_sys);
        if (configClockOe && configClockOut && !last) n++;
        last = configClockOut;
      end
      `CHK(userMode, 1'b1)
      `CHK(doneWire, 1'b1)
      `CHK(weakPullUpEnable, ~keepPortAfterConfig)
      if (~m[2] | ~m[0]) `CHK(n >= 100 && n <= 500, 1'b1)
      cyc(2);
      `CHK(configClockOe, 1'b0)
      doneBitProgrammed <= 1'b0;
      wakeupComplete <= 1'b0;
    end
    cyc(10);
    finish_test();
  end
endmodule : cfgp_pin_ctrl_test
